// >>> common/rsc_pkg.sv
// Purpose: Shared constants and types for the reset strap capture block
// Assumes: 40 MHz pclk, 32-bit APB with byte addresses
// Notes: Level codes are formed from two samples of each configuration pin
package rsc_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;
  localparam int SETTLE_NS = 200;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] PHASE_LAST = 5'(SETTLE_CYC + SYNC_STAGES);
  localparam int SYNC_W = 8;

  // ****************************************************************
  // APB register map
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MGMT = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_LED = 8'h0c;

  // Status fields
  localparam int ST_REFCLK_POS = 0;
  localparam int ST_PLL_POS = 1;
  localparam int ST_MACCLK_POS = 2;
  localparam int ST_DONE_POS = 3;
  localparam int ST_PD_POS = 4;
  localparam int ST_PLLEN_POS = 5;
  localparam int ST_CODES_POS = 8;

  // Management register fields
  localparam int MGMT_ADDR_POS = 0;
  localparam int MGMT_PAUSE_POS = 3;

  // Mode register fields
  localparam int MODE_BITS_POS = 0;
  localparam int MODE_CLKDIS_POS = 4;

  // LED control fields
  localparam int LED_EN_POS = 0;
  localparam int LED_TEST_POS = 1;

  // Values after reset
  localparam logic [2:0] MGMT_ADDR_RST = 3'h0;
  localparam logic PAUSE_RST = 1'b0;
  localparam logic [3:0] MODE_BITS_RST = 4'h0;
  localparam logic CLKDIS_RST = 1'b0;
  localparam logic LED_EN_RST = 1'b1;
  localparam logic LED_TEST_RST = 1'b0;

  // ****************************************************************
  // Encodings
  // ****************************************************************
  localparam logic [1:0] LVL_GND = 2'h0;
  localparam logic [1:0] LVL_FAST = 2'h1;
  localparam logic [1:0] LVL_GIG = 2'h2;
  localparam logic [1:0] LVL_SUPPLY = 2'h3;

  localparam logic [1:0] SPD_SLOW = 2'h0;
  localparam logic [1:0] SPD_FAST = 2'h1;
  localparam logic [1:0] SPD_GIG = 2'h2;

  typedef enum logic [1:0] {
    CAP_RELEASE = 2'b00,
    CAP_DRIVE_A = 2'b01,
    CAP_DRIVE_B = 2'b10,
    CAP_DONE = 2'b11
  } rsc_state_type;

  // Sample a taken with fast LED high, sample b with gig LED high
  function automatic logic [1:0] rsc_level_code(input logic smp_a, input logic smp_b);
    rsc_level_code = {smp_b, smp_a};
  endfunction

endpackage

// >>> verilog/rsc_sync.sv
// Purpose: Two-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to pclk
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module rsc_sync
  import rsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);

  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] sync_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// >>> verilog/rsc_level_decode.sv
// Purpose: Turns two samples of each configuration pin into a level code
// Assumes: Pin levels are already synchronised
// Notes: GND 00, fast LED 01, gig LED 10, supply 11
`timescale 1ns/100ps
module rsc_level_decode
  import rsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] pin_lvl,
  input wire logic grab_a,
  input wire logic grab_b,
  output logic [7:0] level_codes
);

  logic [3:0] smp_a_ff;
  logic [7:0] codes_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_a_ff <= '0;
    end else if (grab_a) begin
      smp_a_ff <= pin_lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      codes_ff <= '0;
    end else if (grab_b) begin
      for (int i = 0; i < 4; i++) begin
        codes_ff[2*i +: 2] <= rsc_level_code(smp_a_ff[i], pin_lvl[i]);
      end
    end
  end

  assign level_codes = codes_ff;

endmodule

// >>> verilog/rsc_strap_top.sv
// Purpose: Captures straps and four-level configuration pins after reset
// Assumes: presetn is the hardware reset; link status comes from pclk logic
// Notes: Strap values hold until the next reset; presets stay writable
// Notes on behaviour
// - capture all straps at reset, hold them
// - refclk strap high selects 125MHz, else 25MHz
// - pll strap high keeps PLL during powerdown
// - config zero sets management address bits 1:0
// - config one sets pause and address bit 2
// - config two sets operating mode bits 1:0
// - config three sets clock disable, mode bit 3
// - drive 10, 100, 1000 link and activity LEDs
// - mac clock strap high 25MHz, low 125MHz
// - powerdown input enters powerdown, PLL per strap
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
module rsc_strap_top
  import rsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cfg_in_zero,
  input wire logic cfg_in_one,
  input wire logic cfg_in_two,
  input wire logic cfg_in_three,
  input wire logic mac_clkout_freq_strap,
  input wire logic hw_powerdown_in,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic link_activity,
  input wire logic link_led_slow_in,
  output logic link_led_slow_out,
  output logic link_led_slow_oe_n,
  input wire logic link_led_fast_in,
  output logic link_led_fast_out,
  output logic link_led_fast_oe_n,
  output logic link_led_gig,
  output logic activity_led,
  output logic refclk_125_sel,
  output logic mac_clkout_125_sel,
  output logic pll_enable,
  output logic powerdown_active,
  output logic [2:0] mgmt_port_addr,
  output logic pause_adv,
  output logic [3:0] op_mode_bits,
  output logic clkout_disable_bit,
  output logic cfg_valid
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [SYNC_W-1:0] pin_sync;
  logic [7:0] level_codes;
  rsc_state_type state_ff;
  rsc_state_type nxt_state;
  logic [4:0] phase_cnt_ff;
  logic phase_end;
  logic grab_strap;
  logic grab_a;
  logic grab_b;
  logic load_preset_ff;
  logic done_ff;
  logic refclk_strap_ff;
  logic pll_strap_ff;
  logic mac_strap_ff;
  logic pd_active_ff;
  logic pll_en_ff;
  logic [2:0] mgmt_addr_ff;
  logic pause_ff;
  logic [3:0] mode_bits_ff;
  logic clkdis_ff;
  logic led_en_ff;
  logic led_test_ff;
  logic slow_out_ff;
  logic slow_oe_n_ff;
  logic fast_out_ff;
  logic fast_oe_n_ff;
  logic gig_out_ff;
  logic act_out_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  logic setup_ph;
  logic wr_acc;
  logic mapped;
  logic [31:0] rd_mux;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  rsc_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({hw_powerdown_in, mac_clkout_freq_strap, link_led_fast_in,
               link_led_slow_in, cfg_in_three, cfg_in_two, cfg_in_one, cfg_in_zero}),
    .sync_out(pin_sync)
  );

  // ****************************************************************
  // Capture sequencer
  // ****************************************************************
  // Each phase waits for the pins to settle and pass the synchroniser
  assign phase_end = (phase_cnt_ff == PHASE_LAST);
  assign grab_strap = (state_ff == CAP_RELEASE) && phase_end;
  assign grab_a = (state_ff == CAP_DRIVE_A) && phase_end;
  assign grab_b = (state_ff == CAP_DRIVE_B) && phase_end;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CAP_RELEASE: begin
        if (phase_end) begin
          nxt_state = CAP_DRIVE_A;
        end
      end
      CAP_DRIVE_A: begin
        if (phase_end) begin
          nxt_state = CAP_DRIVE_B;
        end
      end
      CAP_DRIVE_B: begin
        if (phase_end) begin
          nxt_state = CAP_DONE;
        end
      end
      CAP_DONE: begin
        nxt_state = CAP_DONE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= CAP_RELEASE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt_ff <= 5'h0;
    end else if (phase_end || state_ff == CAP_DONE) begin
      phase_cnt_ff <= 5'h0;
    end else begin
      phase_cnt_ff <= phase_cnt_ff + 5'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_preset_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      load_preset_ff <= grab_b;
      if (load_preset_ff) begin
        done_ff <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Two-level straps
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refclk_strap_ff <= 1'b0;
      pll_strap_ff <= 1'b0;
      mac_strap_ff <= 1'b0;
    end else if (grab_strap) begin
      refclk_strap_ff <= pin_sync[4];
      pll_strap_ff <= pin_sync[5];
      mac_strap_ff <= pin_sync[6];
    end
  end

  // ****************************************************************
  // Four-level configuration inputs
  // ****************************************************************
  rsc_level_decode u_decode (
    .pclk(pclk),
    .presetn(presetn),
    .pin_lvl(pin_sync[3:0]),
    .grab_a(grab_a),
    .grab_b(grab_b),
    .level_codes(level_codes)
  );

  // ****************************************************************
  // Hardware power-down
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_active_ff <= 1'b0;
      pll_en_ff <= 1'b1;
    end else begin
      pd_active_ff <= pin_sync[7] && done_ff;
      pll_en_ff <= !(pin_sync[7] && done_ff && !pll_strap_ff);
    end
  end

  // ****************************************************************
  // APB slave
  // ****************************************************************
  assign setup_ph = psel && !penable;
  assign mapped = (paddr == ADDR_STATUS) || (paddr == ADDR_MGMT) ||
                  (paddr == ADDR_MODE) || (paddr == ADDR_LED);
  assign wr_acc = psel && penable && pwrite && mapped;

  always_comb begin
    rd_mux = 32'h0;
    unique case (paddr)
      ADDR_STATUS: begin
        rd_mux[ST_REFCLK_POS] = refclk_strap_ff;
        rd_mux[ST_PLL_POS] = pll_strap_ff;
        rd_mux[ST_MACCLK_POS] = mac_strap_ff;
        rd_mux[ST_DONE_POS] = done_ff;
        rd_mux[ST_PD_POS] = pd_active_ff;
        rd_mux[ST_PLLEN_POS] = pll_en_ff;
        rd_mux[ST_CODES_POS +: 8] = level_codes;
      end
      ADDR_MGMT: begin
        rd_mux[MGMT_ADDR_POS +: 3] = mgmt_addr_ff;
        rd_mux[MGMT_PAUSE_POS] = pause_ff;
      end
      ADDR_MODE: begin
        rd_mux[MODE_BITS_POS +: 4] = mode_bits_ff;
        rd_mux[MODE_CLKDIS_POS] = clkdis_ff;
      end
      ADDR_LED: begin
        rd_mux[LED_EN_POS] = led_en_ff;
        rd_mux[LED_TEST_POS] = led_test_ff;
      end
      default: begin
        rd_mux = 32'h0;
      end
    endcase
  end

  // Read data and error are fixed in the setup cycle for a zero-wait access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0;
      pslverr_ff <= 1'b0;
    end else if (setup_ph) begin
      prdata_ff <= pwrite ? 32'h0 : rd_mux;
      pslverr_ff <= !mapped;
    end
  end

  // ****************************************************************
  // Preset registers, loaded from the decoded levels, and the LED control register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_addr_ff <= MGMT_ADDR_RST;
      pause_ff <= PAUSE_RST;
    end else if (load_preset_ff) begin
      mgmt_addr_ff[1:0] <= level_codes[1:0];
      mgmt_addr_ff[2] <= level_codes[2];
      pause_ff <= level_codes[3];
    end else if (wr_acc && paddr == ADDR_MGMT) begin
      mgmt_addr_ff <= pwdata[MGMT_ADDR_POS +: 3];
      pause_ff <= pwdata[MGMT_PAUSE_POS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_bits_ff <= MODE_BITS_RST;
      clkdis_ff <= CLKDIS_RST;
    end else if (load_preset_ff) begin
      mode_bits_ff[1:0] <= level_codes[5:4];
      mode_bits_ff[3] <= level_codes[6];
      clkdis_ff <= level_codes[7];
    end else if (wr_acc && paddr == ADDR_MODE) begin
      mode_bits_ff <= pwdata[MODE_BITS_POS +: 4];
      clkdis_ff <= pwdata[MODE_CLKDIS_POS];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_en_ff <= LED_EN_RST;
      led_test_ff <= LED_TEST_RST;
    end else if (wr_acc && paddr == ADDR_LED) begin
      led_en_ff <= pwdata[LED_EN_POS];
      led_test_ff <= pwdata[LED_TEST_POS];
    end
  end

  // ****************************************************************
  // LED drivers
  // ****************************************************************
  // Strap LEDs float in the release phase; fast and gig form the test pattern
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_out_ff <= 1'b0;
      slow_oe_n_ff <= 1'b1;
      fast_out_ff <= 1'b0;
      fast_oe_n_ff <= 1'b1;
      gig_out_ff <= 1'b0;
      act_out_ff <= 1'b0;
    end else begin
      unique case (nxt_state)
        CAP_RELEASE: begin
          slow_out_ff <= 1'b0;
          slow_oe_n_ff <= 1'b1;
          fast_out_ff <= 1'b0;
          fast_oe_n_ff <= 1'b1;
          gig_out_ff <= 1'b0;
          act_out_ff <= 1'b0;
        end
        CAP_DRIVE_A: begin
          slow_out_ff <= 1'b0;
          slow_oe_n_ff <= 1'b1;
          fast_out_ff <= 1'b1;
          fast_oe_n_ff <= 1'b0;
          gig_out_ff <= 1'b0;
          act_out_ff <= 1'b0;
        end
        CAP_DRIVE_B: begin
          slow_out_ff <= 1'b0;
          slow_oe_n_ff <= 1'b1;
          fast_out_ff <= 1'b0;
          fast_oe_n_ff <= 1'b0;
          gig_out_ff <= 1'b1;
          act_out_ff <= 1'b0;
        end
        CAP_DONE: begin
          slow_oe_n_ff <= 1'b0;
          fast_oe_n_ff <= 1'b0;
          slow_out_ff <= led_test_ff ||
                         (led_en_ff && link_up && link_speed == SPD_SLOW);
          fast_out_ff <= led_test_ff ||
                         (led_en_ff && link_up && link_speed == SPD_FAST);
          gig_out_ff <= led_test_ff ||
                        (led_en_ff && link_up && link_speed == SPD_GIG);
          act_out_ff <= led_test_ff || (led_en_ff && link_up && link_activity);
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = pslverr_ff;
  assign link_led_slow_out = slow_out_ff;
  assign link_led_slow_oe_n = slow_oe_n_ff;
  assign link_led_fast_out = fast_out_ff;
  assign link_led_fast_oe_n = fast_oe_n_ff;
  assign link_led_gig = gig_out_ff;
  assign activity_led = act_out_ff;
  assign refclk_125_sel = refclk_strap_ff;
  assign mac_clkout_125_sel = !mac_strap_ff;
  assign pll_enable = pll_en_ff;
  assign powerdown_active = pd_active_ff;
  assign mgmt_port_addr = mgmt_addr_ff;
  assign pause_adv = pause_ff;
  assign op_mode_bits = mode_bits_ff;
  assign clkout_disable_bit = clkdis_ff;
  assign cfg_valid = done_ff;

endmodule

// >>> tb/rsc_strap_chk.sv
// Purpose: Port checks for the strap capture block
// Assumes: Three capture phases of 11 cycles follow reset release
// Notes: Phase windows keep a margin at their borders
`timescale 1ns/100ps
module rsc_strap_chk
  import rsc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic hw_powerdown_in,
  input wire logic link_up,
  input wire logic [1:0] link_speed,
  input wire logic link_activity,
  input wire logic link_led_slow_out,
  input wire logic link_led_slow_oe_n,
  input wire logic link_led_fast_out,
  input wire logic link_led_fast_oe_n,
  input wire logic link_led_gig,
  input wire logic activity_led,
  input wire logic refclk_125_sel,
  input wire logic mac_clkout_125_sel,
  input wire logic pll_enable,
  input wire logic powerdown_active,
  input wire logic cfg_valid
);
  // ****************************************************************
  // Cycles since reset release
  // ****************************************************************
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  assign nxt_cnt = (cnt_ff == 6'h3f) ? cnt_ff : cnt_ff + 6'h01;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 6'h00;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_drive_a;
    link_led_fast_out && !link_led_fast_oe_n && !link_led_gig;
  endsequence
  sequence s_drive_b;
    !link_led_fast_out && !link_led_fast_oe_n && link_led_gig;
  endsequence
  property p_release;
    cnt_ff >= 6'h01 && cnt_ff <= 6'h08 |->
      link_led_fast_oe_n && link_led_slow_oe_n && !link_led_gig && !activity_led;
  endproperty
  a_release: assert property (p_release) else $error("LED pins not released");
  property p_phases;
    cnt_ff == 6'h0e |-> s_drive_a [*6] ##5 s_drive_b [*6];
  endproperty
  a_phases: assert property (p_phases) else $error("Drive phases wrong");
  property p_valid_rise;
    cnt_ff == 6'h21 |-> !cfg_valid ##1 cfg_valid;
  endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("Capture timing wrong");
  property p_valid_hold;
    cfg_valid |=> cfg_valid && $stable(refclk_125_sel);
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("Capture not held");
  property p_mac_hold;
    cfg_valid |=> $stable(mac_clkout_125_sel);
  endproperty
  a_mac_hold: assert property (p_mac_hold) else $error("MAC clock select moved");
  property p_pll;
    !pll_enable |-> powerdown_active;
  endproperty
  a_pll: assert property (p_pll) else $error("PLL off outside powerdown");
  property p_pd_on;
    (cfg_valid && hw_powerdown_in) [*5] |-> powerdown_active;
  endproperty
  a_pd_on: assert property (p_pd_on) else $error("Powerdown not entered");
  property p_pd_off;
    (!hw_powerdown_in) [*5] |-> !powerdown_active && pll_enable;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("Powerdown not left");
  property p_gig;
    cfg_valid && link_up |=> activity_led == $past(link_activity) &&
      {link_led_slow_out, link_led_fast_out, link_led_gig} == 3'b100 >> $past(link_speed);
  endproperty
  a_gig: assert property (p_gig) else $error("Link LED wrong");
  property p_dark;
    cfg_valid && !link_up |=> !link_led_gig && !link_led_slow_out && !link_led_fast_out;
  endproperty
  a_dark: assert property (p_dark) else $error("Link LED lit without link");
endmodule

bind rsc_strap_top rsc_strap_chk rsc_strap_chk_inst (.pclk(pclk), .presetn(presetn),
  .hw_powerdown_in(hw_powerdown_in), .link_up(link_up), .link_speed(link_speed),
  .link_led_slow_out(link_led_slow_out), .link_led_slow_oe_n(link_led_slow_oe_n),
  .link_led_fast_out(link_led_fast_out), .link_led_fast_oe_n(link_led_fast_oe_n),
  .link_led_gig(link_led_gig), .activity_led(activity_led), .refclk_125_sel(refclk_125_sel),
  .mac_clkout_125_sel(mac_clkout_125_sel), .pll_enable(pll_enable),
  .powerdown_active(powerdown_active), .cfg_valid(cfg_valid), .link_activity(link_activity));

// >>> tb/rsc_board_model.sv
// Purpose: Board wiring around the strap and configuration pins
// Assumes: Pull resistors on the LED strap pins
// Notes: Tie code 0 ground, 1 fast LED, 2 gig LED, 3 I/O supply
`timescale 1ns/100ps
module rsc_board_model
(
  input wire logic [7:0] tie_sel,
  input wire logic slow_pull,
  input wire logic fast_pull,
  input wire logic mac_pull,
  input wire logic link_led_slow_out,
  input wire logic link_led_slow_oe_n,
  input wire logic link_led_fast_out,
  input wire logic link_led_fast_oe_n,
  input wire logic link_led_gig,
  output logic link_led_slow_in,
  output logic link_led_fast_in,
  output logic cfg_in_zero,
  output logic cfg_in_one,
  output logic cfg_in_two,
  output logic cfg_in_three,
  output logic mac_clkout_freq_strap
);
  function automatic logic tie(input logic [1:0] s, input logic fast, input logic gig);
    case (s)
      2'h0: tie = 1'b0;
      2'h1: tie = fast;
      2'h2: tie = gig;
      default: tie = 1'b1;
    endcase
  endfunction
  // Released pin falls back to its resistor
  assign link_led_slow_in = link_led_slow_oe_n ? slow_pull : link_led_slow_out;
  assign link_led_fast_in = link_led_fast_oe_n ? fast_pull : link_led_fast_out;
  assign mac_clkout_freq_strap = mac_pull;
  assign cfg_in_zero = tie(tie_sel[1:0], link_led_fast_in, link_led_gig);
  assign cfg_in_one = tie(tie_sel[3:2], link_led_fast_in, link_led_gig);
  assign cfg_in_two = tie(tie_sel[5:4], link_led_fast_in, link_led_gig);
  assign cfg_in_three = tie(tie_sel[7:6], link_led_fast_in, link_led_gig);
endmodule

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the strap capture block
// Assumes: Board model supplies all strap and configuration pin levels
// Notes: Each pass resets the block with fresh ties
`timescale 1ns/100ps
module testbench
  import rsc_pkg::*;
;
  typedef struct {string nm; logic [32:0] v;} rsc_exp_type;
  rsc_exp_type exp_q[$];
  int n_fail = 0;
  int cmp_count = 0;
  logic [31:0] rnd = 32'hefcb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic hw_powerdown_in = 1'b0;
  logic link_up = 1'b0;
  logic [1:0] link_speed = 2'h0;
  logic link_activity = 1'b0;
  logic [7:0] tie_sel = 8'h00;
  logic slow_pull = 1'b0;
  logic fast_pull = 1'b0;
  logic mac_pull = 1'b0;
  logic cv_prev = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, c0, c1, c2, c3, mac_in, s_in, s_out, s_oe_n, f_in, f_out, f_oe_n;
  logic gig, act, refclk_125_sel, mac_clkout_125_sel, pll_enable, powerdown_active;
  logic [2:0] mgmt_port_addr;
  logic pause_adv, clkout_disable_bit, cfg_valid;
  logic [3:0] op_mode_bits;
  rsc_strap_top rsc_strap_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cfg_in_zero(c0), .cfg_in_one(c1), .cfg_in_two(c2),
    .cfg_in_three(c3), .mac_clkout_freq_strap(mac_in), .hw_powerdown_in(hw_powerdown_in),
    .link_up(link_up), .link_speed(link_speed), .link_activity(link_activity),
    .link_led_slow_in(s_in), .link_led_slow_out(s_out), .link_led_slow_oe_n(s_oe_n),
    .link_led_fast_in(f_in), .link_led_fast_out(f_out), .link_led_fast_oe_n(f_oe_n),
    .link_led_gig(gig), .activity_led(act), .refclk_125_sel(refclk_125_sel),
    .mac_clkout_125_sel(mac_clkout_125_sel), .pll_enable(pll_enable),
    .powerdown_active(powerdown_active), .mgmt_port_addr(mgmt_port_addr),
    .pause_adv(pause_adv), .op_mode_bits(op_mode_bits),
    .clkout_disable_bit(clkout_disable_bit), .cfg_valid(cfg_valid));
  rsc_board_model rsc_board_model_inst (.tie_sel(tie_sel), .slow_pull(slow_pull),
    .fast_pull(fast_pull), .mac_pull(mac_pull), .link_led_slow_out(s_out),
    .link_led_slow_oe_n(s_oe_n), .link_led_fast_out(f_out), .link_led_fast_oe_n(f_oe_n),
    .link_led_gig(gig), .link_led_slow_in(s_in), .link_led_fast_in(f_in),
    .cfg_in_zero(c0), .cfg_in_one(c1), .cfg_in_two(c2), .cfg_in_three(c3),
    .mac_clkout_freq_strap(mac_in));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) n_fail++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back('{nm, e});
    apb(1'b0, a, lfsr(rnd));
  endtask
  // ****************************************************************
  // Clock, watcher, watchdog
  // ****************************************************************
  initial begin
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    rsc_exp_type e;
    if (!presetn) begin
      cv_prev = 1'b0;
    end else begin
      if (psel && penable && pready && !pwrite) begin
        e = exp_q.pop_front();
        check(e.nm, {pslverr, prdata}, e.v);
      end
      if (cfg_valid === 1'b1 && !cv_prev) begin
        e = exp_q.pop_front();
        check(e.nm, {20'h0, mgmt_port_addr, pause_adv, op_mode_bits,
          clkout_disable_bit, refclk_125_sel, mac_clkout_125_sel,
          pll_enable, powerdown_active}, e.v);
      end
      cv_prev = cfg_valid;
    end
  end
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    summarize();
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [7:0] s;
    logic [2:0] ad;
    logic [3:0] om;
    logic [32:0] st;
    int n;
    for (int it = 0; it < 7; it++) begin
      rnd = lfsr(rnd);
      s = (it < 4) ? {4{it[1:0]}} : rnd[7:0];
      @(posedge pclk);
      presetn <= 1'b0;
      tie_sel <= s;
      slow_pull <= it[1];
      fast_pull <= it[0];
      mac_pull <= it[2] ^ it[0];
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      ad = {s[2], s[1:0]};
      om = {s[6], 1'b0, s[5:4]};
      exp_q.push_back('{"capture", {20'h0, ad, s[3], om, s[7], it[1], ~(it[2] ^ it[0]),
        2'b10}});
      st = {17'h0, s, 2'b00, 1'b1, 1'b0, 1'b1, it[2] ^ it[0], it[0], it[1]};
      n = 0;
      while (cfg_valid !== 1'b1 && n < 100) begin
        n++;
        @(posedge pclk);
      end
      if (n >= 100) n_fail++;
      tie_sel <= ~s;
      mac_pull <= ~mac_pull;
      rd("status", ADDR_STATUS, st);
      rd("mgmt", ADDR_MGMT, {29'h0, s[3], ad});
      rd("mode", ADDR_MODE, {28'h0, s[7], om});
      rd("led", ADDR_LED, {31'h0, LED_TEST_RST, LED_EN_RST});
      rnd = lfsr(rnd);
      apb(1'b1, ADDR_MGMT, rnd);
      apb(1'b1, ADDR_MODE, rnd);
      apb(1'b1, ADDR_STATUS, rnd);
      apb(1'b1, 8'h11, ~rnd);
      rd("mgmt_wr", ADDR_MGMT, {29'h0, rnd[3:0]});
      rd("mode_wr", ADDR_MODE, {28'h0, rnd[4:0]});
      rd("status_ro", ADDR_STATUS, st);
      rd("unmapped", 8'h10, {1'b1, 32'h0});
      apb(1'b1, ADDR_LED, 32'h1);
      repeat (16) begin
        @(posedge pclk);
        rnd = lfsr(rnd);
        link_up <= rnd[0];
        link_speed <= (rnd[2:1] == 2'h3) ? SPD_GIG : rnd[2:1];
        link_activity <= rnd[3];
      end
      @(posedge pclk);
      link_up <= 1'b0;
      hw_powerdown_in <= 1'b1;
      repeat (6) @(posedge pclk);
      st[5:4] = {it[0], 1'b1};
      rd("status_pd", ADDR_STATUS, st);
      hw_powerdown_in <= 1'b0;
      repeat (6) @(posedge pclk);
    end
    summarize();
  end
endmodule
